// ===== hdl/ppcs_top.sv
// Port power routing, CC steering and port data multiplexer control
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Without main supply, with dead battery supported, present sink, run from VBUS
// - Classify config pin into one of three ranges
// - No-routing range: boot from flash, no routing
// - No-routing range: both high-voltage switches off
// - Internal range: close internal high-voltage switch
// - External range: drive external switch gates on
// - Internal off and VBUS high: pulldown on
// - Pulldown off within threshold of rail
// - Safe-zero request with internal off keeps pulldown until zero
// - Cable power on one CC pin by orientation
// - Other CC pin goes to BMC modem
// - Cable current limit selectable between two settings
// - Mux selection from orientation and interface type
// - UART paths buffered with per-path tri-state
// - Sideband pair may bypass buffering as analog
// - Core-passed signals sampled and driven at clk
// - USB top and bottom swapped by orientation
// - Reset crossbar loops UART receive to transmit
// - Sideband outputs swapped by orientation
module ppcs_top
  import ppcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic main_supply_input_i,
  input wire logic dead_battery_supported_i,
  input wire logic [1:0] dead_battery_config_pin_i,
  input wire logic vbus_above_rail_i,
  input wire logic vbus_at_safe_zero_i,
  input wire logic orientation_flip_i,
  input wire logic cable_ilim_trip_i,
  output logic sink_advertise_o,
  output logic run_from_vbus_o,
  output logic boot_from_flash_o,
  output ppcs_pkg::ppcs_range_e boot_range_o,
  output logic internal_high_voltage_path_en_o,
  output logic external_high_voltage_path_gate_o,
  output logic vbus_pulldown_en_o,
  output logic cc1_power_en_o,
  output logic cc2_power_en_o,
  output logic cc1_modem_en_o,
  output logic cc2_modem_en_o,
  output logic cable_path_current_limit_high_o,
  output logic cable_limit_active_o,
  output logic usb_top_to_system_o,
  output logic usb_bottom_to_system_o,
  output logic usb_swap_o,
  output logic sideband_swap_o,
  output logic sideband_analog_o,
  output logic [1:0] iface_sel_o,
  input wire logic uart_rx_i,
  output logic uart_tx_o,
  output logic uart_tx_oe_o,
  input wire logic core_uart_tx_i,
  output logic core_uart_rx_o,
  input wire logic sideband_serial_pair_rx_i,
  output logic sideband_serial_pair_tx_o,
  output logic sideband_serial_pair_tx_oe_o,
  input wire logic core_sb_tx_i,
  output logic core_sb_rx_o
);
  logic [31:0] ctrl;
  logic [31:0] mux;
  logic [1:0] cfg_sync;
  logic [2:0] pin_sync;
  logic [2:0] flag_sync;
  logic [7:0] cap_cnt;
  logic captured;
  ppcs_range_e range;
  logic safe_zero_timeout;
  logic flip;
  logic wb_hit;
  logic wb_wr;
  logic [31:0] status;
  logic [1:0] supply_sync;
  logic dead_batt;

  function automatic logic [31:0] ppcs_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Strap and analog comparator inputs come from outside the clock domain
  ppcs_sync3 #(.W(2), .INIT(2'b11)) u_cfg_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(dead_battery_config_pin_i),
    .q_o(cfg_sync)
  );

  // Supply and strap levels are pins too, so they get the same filtering
  ppcs_sync3 #(.W(2), .INIT(2'b00)) u_supply_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({main_supply_input_i, dead_battery_supported_i}),
    .q_o(supply_sync)
  );

  ppcs_sync3 #(.W(3), .INIT(3'b000)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({orientation_flip_i, uart_rx_i, sideband_serial_pair_rx_i}),
    .q_o(pin_sync)
  );

  ppcs_sync3 #(.W(3), .INIT(3'b000)) u_flag_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({vbus_above_rail_i, vbus_at_safe_zero_i, cable_ilim_trip_i}),
    .q_o(flag_sync)
  );

  assign flip = pin_sync[2];
  assign dead_batt = !supply_sync[1] && supply_sync[0];

  // Range is taken once the synchroniser has settled, then frozen for the session
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_cnt <= 8'h00;
      captured <= 1'b0;
      range <= PPCS_RANGE_NONE;
    end else if (!captured) begin
      if (cap_cnt == 8'(CAPTURE_DELAY_CYCLES)) begin
        captured <= 1'b1;
        case (cfg_sync)
          2'b11: range <= PPCS_RANGE_NO_ROUTING;
          2'b01: range <= PPCS_RANGE_INTERNAL;
          2'b00: range <= PPCS_RANGE_EXTERNAL;
          default: range <= PPCS_RANGE_NO_ROUTING;
        endcase
      end else begin
        cap_cnt <= cap_cnt + 8'h01;
      end
    end
  end

  assign boot_range_o = range;

  // Dead-battery power routing; firmware may release the boot forcing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sink_advertise_o <= 1'b0;
      run_from_vbus_o <= 1'b0;
      boot_from_flash_o <= 1'b0;
      internal_high_voltage_path_en_o <= 1'b0;
      external_high_voltage_path_gate_o <= 1'b0;
    end else begin
      sink_advertise_o <= dead_batt;
      run_from_vbus_o <= dead_batt;
      boot_from_flash_o <= (range == PPCS_RANGE_NO_ROUTING);
      if (ctrl[CTRL_PATHS_RELEASE] || !captured || range == PPCS_RANGE_NO_ROUTING) begin
        internal_high_voltage_path_en_o <= 1'b0;
        external_high_voltage_path_gate_o <= 1'b0;
      end else begin
        internal_high_voltage_path_en_o <= (range == PPCS_RANGE_INTERNAL);
        external_high_voltage_path_gate_o <= (range == PPCS_RANGE_EXTERNAL);
      end
    end
  end

  ppcs_vbus_discharge u_dis (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .internal_path_on_i(internal_high_voltage_path_en_o),
    .above_rail_thresh_i(flag_sync[2]),
    .safe_zero_req_i(ctrl[CTRL_SAFE0_REQ]),
    .at_safe_zero_i(flag_sync[1]),
    .pulldown_en_o(vbus_pulldown_en_o),
    .safe_zero_timeout_o(safe_zero_timeout)
  );

  // CC steering: power goes to one pin only, modem to the other
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cc1_power_en_o <= 1'b0;
      cc2_power_en_o <= 1'b0;
      cc1_modem_en_o <= 1'b0;
      cc2_modem_en_o <= 1'b0;
      cable_path_current_limit_high_o <= 1'b0;
      cable_limit_active_o <= 1'b0;
    end else begin
      cc1_power_en_o <= ctrl[CTRL_CABLE_PWR_EN] && flip;
      cc2_power_en_o <= ctrl[CTRL_CABLE_PWR_EN] && !flip;
      cc1_modem_en_o <= !flip;
      cc2_modem_en_o <= flip;
      cable_path_current_limit_high_o <= ctrl[CTRL_ILIM_HIGH];
      cable_limit_active_o <= flag_sync[0] && ctrl[CTRL_CABLE_PWR_EN];
    end
  end

  // Multiplexer selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      usb_swap_o <= 1'b0;
      sideband_swap_o <= 1'b0;
      sideband_analog_o <= 1'b0;
      iface_sel_o <= 2'b00;
      usb_top_to_system_o <= 1'b0;
      usb_bottom_to_system_o <= 1'b0;
    end else begin
      usb_swap_o <= flip;
      sideband_swap_o <= flip;
      sideband_analog_o <= mux[MUX_SB_ANALOG];
      iface_sel_o <= mux[MUX_IFACE_LSB +: 2];
      usb_top_to_system_o <= (mux[MUX_IFACE_LSB +: 2] != 2'(PPCS_IF_NONE)) && !flip;
      usb_bottom_to_system_o <= (mux[MUX_IFACE_LSB +: 2] != 2'(PPCS_IF_NONE)) && flip;
    end
  end

  // Buffered UART paths, registered at the core clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uart_tx_o <= 1'b1;
      uart_tx_oe_o <= 1'b0;
      core_uart_rx_o <= 1'b1;
      sideband_serial_pair_tx_o <= 1'b1;
      sideband_serial_pair_tx_oe_o <= 1'b0;
      core_sb_rx_o <= 1'b1;
    end else begin
      uart_tx_o <= mux[MUX_XBAR_FW] ? core_uart_tx_i : pin_sync[1];
      uart_tx_oe_o <= mux[MUX_UART_OE];
      core_uart_rx_o <= pin_sync[1];
      sideband_serial_pair_tx_o <= core_sb_tx_i;
      // Analog bypass leaves the pin to the pass switch
      sideband_serial_pair_tx_oe_o <= mux[MUX_SB_OE] && !mux[MUX_SB_ANALOG];
      core_sb_rx_o <= pin_sync[0];
    end
  end

  // Wishbone classic slave: ack follows one cycle after the request is taken
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_hit && wb_we_i;

  // Status bits are read-only; a write to them is acked and dropped
  assign status = {22'h0, safe_zero_timeout, cable_limit_active_o, vbus_pulldown_en_o, flip, captured,
                   range, 1'b0, internal_high_voltage_path_en_o, external_high_voltage_path_gate_o};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  // Read data is loaded with the ack and then held until the next access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_hit) begin
      case (wb_adr_i[3:0])
        ADDR_CTRL: begin
          wb_dat_o <= ctrl;
        end
        ADDR_MUX: begin
          wb_dat_o <= mux;
        end
        ADDR_STATUS: begin
          wb_dat_o <= status;
        end
        default: begin
          wb_dat_o <= 32'h0;
        end
      endcase
    end
  end

  // Unused bits are masked, except mux bits 2 and 3, so a read shows only what the hardware keeps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
    end else if (wb_wr && wb_adr_i[3:0] == ADDR_CTRL) begin
      ctrl <= ppcs_merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_000F;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mux <= MUX_RESET;
    end else if (wb_wr && wb_adr_i[3:0] == ADDR_MUX) begin
      mux <= ppcs_merge(mux, wb_dat_i, wb_sel_i) & 32'h0000_00FF;
    end
  end
endmodule // ppcs_top

// ===== hdl/ppcs_pkg.sv
// Constants, register map and types for the port power and CC steering block
package ppcs_pkg;
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned SAFE_ZERO_TIME_MS = 650;
  localparam int unsigned SAFE_ZERO_CYCLES = (SAFE_ZERO_TIME_MS * (CLK_FREQ_HZ / 1000));
  localparam int unsigned CAPTURE_DELAY_CYCLES = 16;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MUX = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  localparam int CTRL_CABLE_PWR_EN = 0;
  localparam int CTRL_ILIM_HIGH = 1;
  localparam int CTRL_SAFE0_REQ = 2;
  localparam int CTRL_PATHS_RELEASE = 3;
  localparam int MUX_IFACE_LSB = 0;
  localparam int MUX_UART_OE = 4;
  localparam int MUX_SB_OE = 5;
  localparam int MUX_SB_ANALOG = 6;
  localparam int MUX_XBAR_FW = 7;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] MUX_RESET = 32'h0000_0030;

  typedef enum logic [1:0] {
    PPCS_RANGE_NONE,
    PPCS_RANGE_NO_ROUTING,
    PPCS_RANGE_INTERNAL,
    PPCS_RANGE_EXTERNAL
  } ppcs_range_e;

  typedef enum logic [1:0] {
    PPCS_IF_NONE,
    PPCS_IF_USB,
    PPCS_IF_ALT,
    PPCS_IF_DEBUG
  } ppcs_iface_e;
endpackage

// ===== hdl/ppcs_sync3.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module ppcs_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Only bits where the second and third stages agree are taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= INIT;
    end else begin
      q_o <= (s2 & s3) | (q_o & (s2 | s3));
    end
  end
endmodule // ppcs_sync3

// ===== hdl/ppcs_vbus_discharge.sv
// VBUS active discharge pulldown control
`timescale 1ns/1ps
module ppcs_vbus_discharge
  import ppcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic internal_path_on_i,
  input wire logic above_rail_thresh_i,
  input wire logic safe_zero_req_i,
  input wire logic at_safe_zero_i,
  output logic pulldown_en_o,
  output logic safe_zero_timeout_o
);
  logic [31:0] safe_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulldown_en_o <= 1'b0;
    end else if (safe_zero_req_i && !at_safe_zero_i && !internal_path_on_i) begin // Closed switch holds VBUS up
      pulldown_en_o <= 1'b1;
    end else if (!internal_path_on_i && above_rail_thresh_i) begin
      pulldown_en_o <= 1'b1;
    end else begin
      pulldown_en_o <= 1'b0;
    end
  end

  // Flags a discharge that overruns the safe-zero budget
  always_ff @(posedge clk_i) begin
    if (rst_i || !safe_zero_req_i || at_safe_zero_i) begin
      safe_cnt <= 32'h0;
      safe_zero_timeout_o <= 1'b0;
    end else if (safe_cnt >= 32'(SAFE_ZERO_CYCLES)) begin
      safe_zero_timeout_o <= 1'b1;
    end else begin
      safe_cnt <= safe_cnt + 32'h1;
    end
  end
endmodule // ppcs_vbus_discharge

// ===== verif/ppcs_top_assertions.sv
// Concurrent checks on the port power and CC steering top ports
`timescale 1ns/1ps
module ppcs_top_assertions
  import ppcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic main_supply_input_i,
  input wire logic dead_battery_supported_i,
  input wire logic orientation_flip_i,
  input wire logic sink_advertise_o,
  input wire logic run_from_vbus_o,
  input wire ppcs_pkg::ppcs_range_e boot_range_o,
  input wire logic internal_high_voltage_path_en_o,
  input wire logic external_high_voltage_path_gate_o,
  input wire logic vbus_pulldown_en_o,
  input wire logic cc1_power_en_o,
  input wire logic cc2_power_en_o,
  input wire logic cc1_modem_en_o,
  input wire logic cc2_modem_en_o,
  input wire logic usb_swap_o,
  input wire logic sideband_swap_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Eight cycles covers the pin synchroniser and output register
  sequence s_dead_battery;
    (!main_supply_input_i && dead_battery_supported_i) [*8];
  endsequence
  sequence s_flip_steady;
    $stable(orientation_flip_i) [*8];
  endsequence
  a_sink_dead_batt: assert property (s_dead_battery |-> sink_advertise_o && run_from_vbus_o)
    else $error("sink not presented on dead battery");
  a_no_route_off: assert property (boot_range_o == PPCS_RANGE_NO_ROUTING |->
    !internal_high_voltage_path_en_o && !external_high_voltage_path_gate_o)
    else $error("power path on in no-routing range");
  a_int_path_range: assert property (internal_high_voltage_path_en_o |-> boot_range_o == PPCS_RANGE_INTERNAL)
    else $error("internal path on outside internal range");
  a_ext_gate_range: assert property (external_high_voltage_path_gate_o |-> boot_range_o == PPCS_RANGE_EXTERNAL)
    else $error("external gate on outside external range");
  a_pulldown_int_off: assert property (internal_high_voltage_path_en_o [*2] |-> !vbus_pulldown_en_o)
    else $error("pulldown on while internal path closed");
  a_cc_one_power: assert property (!(cc1_power_en_o && cc2_power_en_o))
    else $error("both CC pins powered");
  a_cc_orient: assert property (s_flip_steady |->
    !(orientation_flip_i ? cc2_power_en_o : cc1_power_en_o))
    else $error("wrong CC pin powered for orientation");
  a_cc_modem_other: assert property ((cc1_power_en_o || cc2_power_en_o) |->
    cc1_modem_en_o == cc2_power_en_o && cc2_modem_en_o == cc1_power_en_o)
    else $error("modem not on the unpowered CC pin");
  a_swap_orient: assert property (s_flip_steady |->
    usb_swap_o == orientation_flip_i && sideband_swap_o == orientation_flip_i)
    else $error("port swap does not follow orientation");
  a_range_held: assert property (boot_range_o != PPCS_RANGE_NONE |=> $stable(boot_range_o))
    else $error("captured range changed within boot");
endmodule // ppcs_top_assertions

bind ppcs_top ppcs_top_assertions chk_u (.clk_i, .rst_i, .main_supply_input_i, .dead_battery_supported_i,
  .orientation_flip_i, .sink_advertise_o, .run_from_vbus_o, .boot_range_o, .internal_high_voltage_path_en_o,
  .external_high_voltage_path_gate_o, .vbus_pulldown_en_o, .cc1_power_en_o, .cc2_power_en_o,
  .cc1_modem_en_o, .cc2_modem_en_o, .usb_swap_o, .sideband_swap_o);

// ===== verif/ppcs_port_partner.sv
// Port partner model: VBUS level that only the pulldown brings down
`timescale 1ns/1ps
module ppcs_port_partner (
  input wire logic clk_i,
  input wire logic pulldown_en_i,
  input wire logic set_i,
  input wire logic [7:0] set_level_i,
  output logic vbus_above_rail_o,
  output logic vbus_at_safe_zero_o
);
  logic [7:0] level = 8'h00;
  // No load decay, so a pulldown left on too long reaches zero
  always @(posedge clk_i) begin
    if (set_i) begin
      level <= set_level_i;
    end else if (pulldown_en_i && level != 8'h00) begin
      level <= level - 8'h01;
    end
  end
  assign vbus_above_rail_o = level > 8'h14;
  assign vbus_at_safe_zero_o = level == 8'h00;
endmodule // ppcs_port_partner

// ===== verif/test_port_power_and_cc_steering.sv
// Self-checking bench for the port power and CC steering block
`timescale 1ns/1ps
module test_port_power_and_cc_steering;
  import ppcs_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, vset = 1'b0;
  logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'hF;
  logic [1:0] dead_battery_config_pin_i = 2'h3, iface_sel_o;
  logic [7:0] vlvl = 8'h00;
  logic main_supply_input_i = 1'b0, dead_battery_supported_i = 1'b1, orientation_flip_i = 1'b0;
  logic cable_ilim_trip_i = 1'b0, uart_rx_i = 1'b1, core_uart_tx_i = 1'b1, sideband_serial_pair_rx_i = 1'b1;
  logic core_sb_tx_i = 1'b1, vbus_above_rail_i, vbus_at_safe_zero_i, wb_ack_o, sink_advertise_o;
  logic run_from_vbus_o, boot_from_flash_o, internal_high_voltage_path_en_o, external_high_voltage_path_gate_o;
  logic vbus_pulldown_en_o, cc1_power_en_o, cc2_power_en_o, cc1_modem_en_o, cc2_modem_en_o;
  logic cable_path_current_limit_high_o, cable_limit_active_o, usb_top_to_system_o, usb_bottom_to_system_o;
  logic usb_swap_o, sideband_swap_o, sideband_analog_o, uart_tx_o, uart_tx_oe_o, core_uart_rx_o;
  logic sideband_serial_pair_tx_o, sideband_serial_pair_tx_oe_o, core_sb_rx_o;
  ppcs_range_e boot_range_o;
  int err_total = 0, comparisons = 0;
  // Row: pin code, orientation, expected range; internal row last for the pulldown cases
  logic [4:0] rows [4] = '{{2'h3, 1'b0, PPCS_RANGE_NO_ROUTING}, {2'h2, 1'b1, PPCS_RANGE_NO_ROUTING},
    {2'h0, 1'b0, PPCS_RANGE_EXTERNAL}, {2'h1, 1'b1, PPCS_RANGE_INTERNAL}};
  always #5 clk_i = ~clk_i;
  ppcs_top dut_u (.*);
  ppcs_port_partner partner_u (.clk_i(clk_i), .pulldown_en_i(vbus_pulldown_en_o), .set_i(vset),
    .set_level_i(vlvl), .vbus_above_rail_o(vbus_above_rail_i), .vbus_at_safe_zero_o(vbus_at_safe_zero_i));
  task automatic print_verdict;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_adr_i <= {28'h0, a};
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic wait_pd(input logic v);
    int n;
    n = 0;
    while (vbus_pulldown_en_o !== v && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk(vbus_pulldown_en_o, v);
    if (vbus_pulldown_en_o !== v) begin
      print_verdict();
    end
  endtask
  initial begin
    tick(8);
    chk(uart_tx_o, 1'b1);
    chk(boot_range_o, PPCS_RANGE_NONE);
    foreach (rows[i]) begin
      dead_battery_config_pin_i <= rows[i][4:3];
      orientation_flip_i <= rows[i][2];
      rst_i <= 1'b1;
      tick(8);
      rst_i <= 1'b0;
      tick(30);
      chk(boot_range_o, rows[i][1:0]);
      chk(boot_from_flash_o, rows[i][1:0] == PPCS_RANGE_NO_ROUTING);
      chk(internal_high_voltage_path_en_o, rows[i][1:0] == PPCS_RANGE_INTERNAL);
      chk(external_high_voltage_path_gate_o, rows[i][1:0] == PPCS_RANGE_EXTERNAL);
      chk({sink_advertise_o, run_from_vbus_o}, 2'h3);
      chk({cc1_power_en_o, cc2_power_en_o, cc1_modem_en_o}, {rows[i][2], !rows[i][2], !rows[i][2]});
      chk({usb_swap_o, sideband_swap_o}, {2{rows[i][2]}});
      dead_battery_config_pin_i <= ~rows[i][4:3];
      tick(30);
      chk(boot_range_o, rows[i][1:0]);
    end
    main_supply_input_i <= 1'b1;
    tick(8);
    chk({sink_advertise_o, run_from_vbus_o}, 2'h0);
    main_supply_input_i <= 1'b0;
    uart_rx_i <= 1'b0;
    tick(6);
    chk(uart_tx_o, 1'b0);
    chk(core_uart_rx_o, 1'b0);
    wb(4'h0, 1'b0, 32'h0);
    chk(rd, CTRL_RESET);
    wb(4'h4, 1'b0, 32'h0);
    chk(rd, MUX_RESET);
    wb(4'hC, 1'b1, 32'hFFFF_FFFF);
    wb(4'hC, 1'b0, 32'h0);
    chk(rd, 32'h0);
    wb(4'h0, 1'b1, 32'h3);
    cable_ilim_trip_i <= 1'b1;
    tick(6);
    chk({cable_path_current_limit_high_o, cable_limit_active_o}, 2'h3);
    for (int k = 0; k < 4; k++) begin
      wb(4'h4, 1'b1, 32'h30 | k);
      tick(2);
      chk(iface_sel_o, k[1:0]);
      chk({usb_top_to_system_o, usb_bottom_to_system_o}, {1'b0, k != 0});
    end
    wb(4'h4, 1'b1, 32'h40);
    tick(2);
    chk({uart_tx_oe_o, sideband_serial_pair_tx_oe_o}, 2'h0);
    chk(sideband_analog_o, 1'b1);
    // Firmware crossbar mode: transmit follows the core, not the looped receive pin
    wb(4'h4, 1'b1, 32'hC0);
    tick(2);
    chk(uart_tx_o, 1'b1);
    // Internal path closed: high VBUS must not start the pulldown
    vlvl <= 8'h28;
    vset <= 1'b1;
    tick(1);
    vset <= 1'b0;
    tick(10);
    chk(vbus_pulldown_en_o, 1'b0);
    wb(4'h0, 1'b1, 32'h9);
    wait_pd(1'b1);
    wait_pd(1'b0);
    chk({vbus_above_rail_i, vbus_at_safe_zero_i}, 2'h0);
    wb(4'h0, 1'b1, 32'hD);
    wait_pd(1'b1);
    wait_pd(1'b0);
    chk(vbus_at_safe_zero_i, 1'b1);
    print_verdict();
  end
endmodule // test_port_power_and_cc_steering
